// ===== src/acsc_defines.svh
/*
 * Constants of the converter start control: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and an 8-bit register port.
 */
`ifndef ACSC_DEFINES_SVH
`define ACSC_DEFINES_SVH

// register offsets
`define ACSC_OFS_CHAN 8'hBB
`define ACSC_OFS_CFG 8'hBC
`define ACSC_OFS_RES_LO 8'hBD
`define ACSC_OFS_RES_HI 8'hBE
`define ACSC_OFS_CTRL 8'hE8

// converter_control_reg fields
`define ACSC_CTRL_DONE 5
`define ACSC_CTRL_BUSY 4
`define ACSC_CTRL_IE 3
`define ACSC_CTRL_SRC_HI 2
`define ACSC_CTRL_SRC_LO 0

// converter_config_reg fields
`define ACSC_CFG_DIV_HI 7
`define ACSC_CFG_DIV_LO 3

// positive_channel_reg field
`define ACSC_CHAN_HI 4
`define ACSC_CHAN_LO 0

// reset values
`define ACSC_RST_CHAN 5'h00
`define ACSC_RST_DIV 5'h1F
`define ACSC_RST_SRC 3'h0

// start source codes
`define ACSC_SRC_SW 3'h0
`define ACSC_SRC_T0 3'h1
`define ACSC_SRC_T2 3'h2
`define ACSC_SRC_T1 3'h3
`define ACSC_SRC_EXT 3'h4
`define ACSC_SRC_T3 3'h5

// timing
`define ACSC_CLK_PERIOD_NS 40
`define ACSC_MIN_PERIOD_NS 5000
`define ACSC_MIN_CYC 8'((`ACSC_MIN_PERIOD_NS + `ACSC_CLK_PERIOD_NS - 1) / `ACSC_CLK_PERIOD_NS)
`define ACSC_CONV_CLKS 4'hD

`endif

// ===== src/acsc_pkg.sv
/*
 * Types of the converter start control: phase enum and state structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acsc_pkg;

   typedef enum logic [1:0] {
      ACSC_IDLE = 2'b00,
      ACSC_CONV = 2'b01
   } acsc_phase_t;

   typedef struct packed {
      acsc_phase_t phase;
      logic busy;
      logic done;
      logic ie;
      logic [2:0] src;
      logic [4:0] div;
      logic [4:0] chan;
      logic [4:0] div_cnt;
      logic [3:0] conv_cnt;
      logic [7:0] per_cnt;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] rdata;
      logic tick;
      logic start;
      logic irq;
   } acsc_state_t;

   typedef struct packed {
      logic prev;
   } acsc_edge_state_t;

endpackage

// ===== src/acsc_edge_detect.sv
/*
 * One-cycle edge detector on a level, rising or falling by parameter.
 * Assumes the level is synchronous to clk_sys_in.
 */
`timescale 1ns/10ps

module acsc_edge_detect #(
   parameter bit RISING = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic level_in,
   output logic edge_out
);

   acsc_pkg::acsc_edge_state_t st_q;
   acsc_pkg::acsc_edge_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.prev = level_in;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign edge_out = RISING ? (level_in & ~st_q.prev) : (~level_in & st_q.prev);

endmodule

// ===== src/acsc_top.sv
/*
 * Converter start control: conversion clock divider, start source
 * selection, busy tracking, done flag, result bytes, channel select.
 * Assumes timer overflow inputs are one-cycle pulses, the external
 * start pin is synchronous to clk_sys_in, and the analog side holds
 * adc_data_in steady at the end of a conversion.
 */
`timescale 1ns/10ps
`include "acsc_defines.svh"

// How it works
// - a conversion never lasts less than five microseconds, so at most 200 ksps.
// - conversion clock is system clock divided by divide field plus one, 0..31.
// - start source field picks the single event that may start a conversion.
// - with software source, writing one to the busy bit starts a conversion.
// - timer zero, one, two or three overflow starts a conversion when selected.
// - with external source, each rising edge on the start pin while idle starts one.
// - busy reads one throughout a conversion and drops to zero when it ends.
// - busy falling sets the done flag and raises interrupt when enabled.
// - result bytes hold the converted value whenever done reads one.
// - timers two and three use low overflow in 8-bit, high in 16-bit mode.
// - channel register holds five writable bits four to zero, reset zero.
module acsc_top (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic tmr0_ovf_in,
   input wire logic tmr1_ovf_in,
   input wire logic tmr2_lo_ovf_in,
   input wire logic tmr2_hi_ovf_in,
   input wire logic tmr2_mode16_in,
   input wire logic tmr3_lo_ovf_in,
   input wire logic tmr3_hi_ovf_in,
   input wire logic tmr3_mode16_in,
   input wire logic external_start_pin_in,
   input wire logic [9:0] adc_data_in,
   output logic [7:0] reg_rdata_out,
   output logic conv_clk_tick_out,
   output logic conv_start_out,
   output logic conv_busy_out,
   output logic [4:0] positive_channel_out,
   output logic irq_out
);

   acsc_pkg::acsc_state_t st_q;
   acsc_pkg::acsc_state_t st_d;

   logic pin_rise;
   logic busy_fall;
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_chan;
   logic trig;
   logic end_conv;

   acsc_edge_detect #(
      .RISING(1'b1)
   ) u_pin_edge (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .level_in(external_start_pin_in),
      .edge_out(pin_rise)
   );

   acsc_edge_detect #(
      .RISING(1'b0)
   ) u_busy_edge (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .level_in(st_q.busy),
      .edge_out(busy_fall)
   );

   always_comb begin
      wr_ctrl = 1'b0;
      wr_cfg = 1'b0;
      wr_chan = 1'b0;
      if (reg_wr_in && reg_addr_in == `ACSC_OFS_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr_in && reg_addr_in == `ACSC_OFS_CFG) begin
         wr_cfg = 1'b1;
      end else if (reg_wr_in && reg_addr_in == `ACSC_OFS_CHAN) begin
         wr_chan = 1'b1;
      end
   end

   always_comb begin
      case (st_q.src)
         `ACSC_SRC_SW: trig = wr_ctrl && reg_wdata_in[`ACSC_CTRL_BUSY];
         `ACSC_SRC_T0: trig = tmr0_ovf_in;
         `ACSC_SRC_T1: trig = tmr1_ovf_in;
         `ACSC_SRC_T2: trig = tmr2_mode16_in ? tmr2_hi_ovf_in : tmr2_lo_ovf_in;
         `ACSC_SRC_T3: trig = tmr3_mode16_in ? tmr3_hi_ovf_in : tmr3_lo_ovf_in;
         `ACSC_SRC_EXT: trig = pin_rise;
         default: trig = 1'b0;
      endcase
   end

   // both clock count and least period
   assign end_conv = (st_q.conv_cnt == `ACSC_CONV_CLKS) && (st_q.per_cnt >= `ACSC_MIN_CYC - 8'h01);

   always_comb begin
      st_d = st_q;
      st_d.tick = 1'b0;
      st_d.start = 1'b0;

      if (wr_cfg) begin
         st_d.div = reg_wdata_in[`ACSC_CFG_DIV_HI:`ACSC_CFG_DIV_LO];
      end
      if (wr_chan) begin
         st_d.chan = reg_wdata_in[`ACSC_CHAN_HI:`ACSC_CHAN_LO];
      end
      if (wr_ctrl) begin
         st_d.ie = reg_wdata_in[`ACSC_CTRL_IE];
         st_d.src = reg_wdata_in[`ACSC_CTRL_SRC_HI:`ACSC_CTRL_SRC_LO];
         // cleared only by a zero write
         if (!reg_wdata_in[`ACSC_CTRL_DONE]) begin
            st_d.done = 1'b0;
         end
      end
      if (busy_fall) begin
         st_d.done = 1'b1;
      end

      case (st_q.phase)
         acsc_pkg::ACSC_IDLE: begin
            if (trig) begin
               st_d.phase = acsc_pkg::ACSC_CONV;
               st_d.busy = 1'b1;
               st_d.start = 1'b1;
               st_d.div_cnt = 5'h00;
               st_d.conv_cnt = 4'h0;
               st_d.per_cnt = 8'h00;
            end
         end
         acsc_pkg::ACSC_CONV: begin
            if (st_q.per_cnt != 8'hFF) begin
               st_d.per_cnt = st_q.per_cnt + 8'h01;
            end
            if (st_q.conv_cnt != `ACSC_CONV_CLKS) begin
               if (st_q.div_cnt == st_q.div) begin
                  st_d.div_cnt = 5'h00;
                  st_d.tick = 1'b1;
                  st_d.conv_cnt = st_q.conv_cnt + 4'h1;
               end else begin
                  st_d.div_cnt = st_q.div_cnt + 5'h01;
               end
            end
            if (end_conv) begin
               st_d.phase = acsc_pkg::ACSC_IDLE;
               st_d.busy = 1'b0;
               st_d.res_hi = {6'h00, adc_data_in[9:8]};
               st_d.res_lo = adc_data_in[7:0];
            end
         end
         default: begin
            st_d.phase = acsc_pkg::ACSC_IDLE;
            st_d.busy = 1'b0;
         end
      endcase

      st_d.irq = st_d.done && st_d.ie;

      st_d.rdata = 8'h00;
      if (reg_rd_in && reg_addr_in == `ACSC_OFS_CTRL) begin
         st_d.rdata = {2'b00, st_q.done, st_q.busy, st_q.ie, st_q.src};
      end else if (reg_rd_in && reg_addr_in == `ACSC_OFS_CFG) begin
         st_d.rdata = {st_q.div, 3'b000};
      end else if (reg_rd_in && reg_addr_in == `ACSC_OFS_CHAN) begin
         st_d.rdata = {3'b000, st_q.chan};
      end else if (reg_rd_in && reg_addr_in == `ACSC_OFS_RES_LO) begin
         st_d.rdata = st_q.res_lo;
      end else if (reg_rd_in && reg_addr_in == `ACSC_OFS_RES_HI) begin
         st_d.rdata = st_q.res_hi;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         st_q <= '0;
         st_q.phase <= acsc_pkg::ACSC_IDLE;
         st_q.div <= `ACSC_RST_DIV;
         st_q.src <= `ACSC_RST_SRC;
         st_q.chan <= `ACSC_RST_CHAN;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_out = st_q.rdata;
   assign conv_clk_tick_out = st_q.tick;
   assign conv_start_out = st_q.start;
   assign conv_busy_out = st_q.busy;
   assign positive_channel_out = st_q.chan;
   assign irq_out = st_q.irq;

   // assertions
   sequence s_idle_trig;
      st_q.phase == acsc_pkg::ACSC_IDLE && trig;
   endsequence

   sequence s_busy_then_low;
      st_q.busy [*8] ##[1:900] !st_q.busy;
   endsequence

   AST_SW_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_SW && !st_q.busy && wr_ctrl && reg_wdata_in[4]) |=> st_q.busy)
      else $error("software start did not set busy");

   AST_ONLY_SELECTED: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (!st_q.busy && !trig) |=> !st_q.busy)
      else $error("conversion started without selected source");

   AST_T0_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T0 && tmr0_ovf_in && !st_q.busy) |=> st_q.busy && conv_start_out)
      else $error("timer zero overflow did not start conversion");

   AST_EXT_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_EXT && external_start_pin_in && !$past(external_start_pin_in)
       && !st_q.busy) |=> st_q.busy)
      else $error("pin rising edge did not start conversion");

   // low overflow ignored in 16-bit mode
   AST_T2_MODE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T2 && tmr2_mode16_in && !tmr2_hi_ovf_in && !st_q.busy)
      |=> !st_q.busy)
      else $error("timer two low overflow started in 16-bit mode");

   AST_BUSY_SPAN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_idle_trig |=> s_busy_then_low)
      else $error("busy not held or never released");

   AST_MIN_PERIOD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $fell(st_q.busy) |-> $past(st_q.per_cnt) >= `ACSC_MIN_CYC - 8'h01)
      else $error("conversion shorter than least period");

   AST_DIV_TICK: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.busy && st_q.conv_cnt != `ACSC_CONV_CLKS && st_q.div_cnt == st_q.div)
      |=> conv_clk_tick_out)
      else $error("conversion clock tick missing");

   AST_DONE_SET: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $fell(st_q.busy) |=> st_q.done && (irq_out == st_q.ie))
      else $error("done or interrupt not raised after busy fall");

   AST_DONE_STICKY: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.done && !(wr_ctrl && !reg_wdata_in[5])) |=> st_q.done)
      else $error("done flag cleared without software");

   AST_RESULT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $fell(st_q.busy) |-> {st_q.res_hi[1:0], st_q.res_lo} == $past(adc_data_in))
      else $error("result bytes do not hold converted value");

   AST_CHAN_WR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      wr_chan |=> positive_channel_out == $past(reg_wdata_in[4:0]))
      else $error("channel register write lost");

   AST_T1_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T1 && tmr1_ovf_in && !st_q.busy) |=> st_q.busy && conv_start_out)
      else $error("timer one overflow did not start conversion");

   AST_T2_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T2 && !st_q.busy
       && (tmr2_mode16_in ? tmr2_hi_ovf_in : tmr2_lo_ovf_in)) |=> st_q.busy)
      else $error("timer two overflow did not start conversion");

   AST_T3_START: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T3 && !st_q.busy
       && (tmr3_mode16_in ? tmr3_hi_ovf_in : tmr3_lo_ovf_in)) |=> st_q.busy)
      else $error("timer three overflow did not start conversion");

   // high overflow ignored in 8-bit mode
   AST_T3_MODE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.src == `ACSC_SRC_T3 && !tmr3_mode16_in && !tmr3_lo_ovf_in && !st_q.busy)
      |=> !st_q.busy)
      else $error("timer three high overflow started in 8-bit mode");

   AST_START_PULSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      conv_start_out == $rose(st_q.busy))
      else $error("start pulse not aligned with busy rising");

   AST_BUSY_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q.busy && st_q.conv_cnt != `ACSC_CONV_CLKS) |=> st_q.busy && !conv_start_out)
      else $error("busy dropped or restarted before conversion clocks done");

   AST_TICK_TOTAL: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $fell(st_q.busy) |-> $past(st_q.conv_cnt) == `ACSC_CONV_CLKS)
      else $error("conversion ended before all conversion clocks");

   AST_NO_TICK_IDLE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !st_q.busy |-> !conv_clk_tick_out)
      else $error("conversion clock tick while idle");

   AST_TICK_SRC: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      conv_clk_tick_out |-> $past(st_q.div_cnt) == $past(st_q.div))
      else $error("conversion clock tick off the divider count");

   AST_RESULT_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !st_q.busy |=> $stable(st_q.res_lo) && $stable(st_q.res_hi))
      else $error("result bytes changed outside a conversion");

   AST_DONE_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (wr_ctrl && !reg_wdata_in[`ACSC_CTRL_DONE] && !busy_fall) |=> !st_q.done)
      else $error("done flag not cleared by zero write");

   AST_CHAN_READ: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == `ACSC_OFS_CHAN)
      |=> reg_rdata_out == {3'b000, $past(st_q.chan)})
      else $error("channel read data wrong");

   AST_RESET_STATE: assert property (@(posedge clk_sys_in)
      !nrst_in |=> st_q.chan == `ACSC_RST_CHAN && st_q.div == `ACSC_RST_DIV
         && !conv_busy_out && !irq_out && reg_rdata_out == 8'h00)
      else $error("state not at reset values after reset");

endmodule

// ===== dv/acsc_far_model.sv
/*
 * Far-side model of the converter start control: timer overflow pulses,
 * timer width modes, external start pin and the analog result.
 * Assumes the bench calls fire and set_modes; lines change after clk edges.
 */
`timescale 1ns/10ps

module acsc_far_model (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic conv_busy_in,
   output logic [6:0] ev_out,
   output logic tmr2_mode16_out,
   output logic tmr3_mode16_out,
   output logic [9:0] adc_data_out
);
   initial begin
      ev_out = 7'h00;
      tmr2_mode16_out = 1'b0;
      tmr3_mode16_out = 1'b0;
      adc_data_out = 10'h000;
   end

   // analog value held steady during a conversion
   always @(posedge clk_sys_in) begin
      if (nrst_in && !conv_busy_in) begin
         adc_data_out <= 10'($urandom);
      end
   end

   task automatic fire(input int k);
      @(posedge clk_sys_in);
      ev_out[k] <= 1'b1;
      @(posedge clk_sys_in);
      ev_out[k] <= 1'b0;
   endtask

   task automatic set_modes(input logic m2, input logic m3);
      @(posedge clk_sys_in);
      tmr2_mode16_out <= m2;
      tmr3_mode16_out <= m3;
   endtask
endmodule

// ===== dv/acsc_top_test.sv
/*
 * Self-checking bench of the converter start control with a far-side model.
 * Assumes the register port answers one cycle after the read strobe.
 */
`timescale 1ns/10ps
`include "acsc_defines.svh"

module acsc_top_test;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] ev;
   logic m2;
   logic m3;
   logic [9:0] adc;
   logic [7:0] rdata;
   logic tick;
   logic start;
   logic busy;
   logic irq;
   logic [4:0] chan;
   logic [7:0] rd_v;
   logic [7:0] v;
   logic [4:0] div;
   logic ie;
   int fail_count = 0;
   int n_tests = 0;
   int start_cnt = 0;
   int cyc_cnt = 0;
   int seed_v;
   int s0;

   initial forever #20 clk_sys_in = ~clk_sys_in;

   acsc_top u_acsc_top (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .tmr0_ovf_in(ev[0]),
      .tmr1_ovf_in(ev[1]), .tmr2_lo_ovf_in(ev[2]), .tmr2_hi_ovf_in(ev[3]),
      .tmr2_mode16_in(m2), .tmr3_lo_ovf_in(ev[4]), .tmr3_hi_ovf_in(ev[5]),
      .tmr3_mode16_in(m3), .external_start_pin_in(ev[6]), .adc_data_in(adc),
      .reg_rdata_out(rdata), .conv_clk_tick_out(tick), .conv_start_out(start),
      .conv_busy_out(busy), .positive_channel_out(chan), .irq_out(irq));

   acsc_far_model u_acsc_far_model (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .conv_busy_in(busy), .ev_out(ev), .tmr2_mode16_out(m2), .tmr3_mode16_out(m3),
      .adc_data_out(adc));

   always @(posedge clk_sys_in) begin
      if (start === 1'b1) start_cnt <= start_cnt + 1;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1 rd_v = rdata;
   endtask

   // event line expected to start a conversion for a source code
   function automatic int right_ev(input logic [2:0] s, input logic a, input logic b);
      case (s)
         `ACSC_SRC_T0: return 0;
         `ACSC_SRC_T1: return 1;
         `ACSC_SRC_T2: return a ? 3 : 2;
         `ACSC_SRC_T3: return b ? 5 : 4;
         `ACSC_SRC_EXT: return 6;
         default: return -1;
      endcase
   endfunction

   // busy cycles: the longer of the least period and all conversion clocks
   function automatic int busy_len(input logic [4:0] d);
      int n;
      n = `ACSC_CONV_CLKS * (d + 1) + 1;
      return (n > `ACSC_MIN_CYC) ? n : `ACSC_MIN_CYC;
   endfunction

   task automatic run_conv(input logic [2:0] s);
      int cyc;
      int ticks;
      int last;
      int bad;
      logic [9:0] exp;
      cyc = 0;
      ticks = 0;
      last = -1;
      bad = 0;
      exp = 10'h000;
      #1;
      while (busy !== 1'b1 && cyc < 4) begin
         @(posedge clk_sys_in);
         #1 cyc++;
      end
      cyc = 0;
      while (busy === 1'b1 && cyc < 600) begin
         if (tick === 1'b1) begin
            if (last >= 0 && cyc - last != div + 1) bad++;
            last = cyc;
            ticks++;
         end
         exp = adc;
         @(posedge clk_sys_in);
         #1 cyc++;
      end
      check("start count", 16'(start_cnt - s0), 16'h0001);
      check("tick gap", 16'(bad), 16'h0000);
      check("tick count", 16'(ticks), 16'(`ACSC_CONV_CLKS));
      check("busy length", 16'(cyc), 16'(busy_len(div)));
      rd(`ACSC_OFS_CTRL);
      check("done and busy", rd_v[5:4], 2'b10);
      check("irq", irq, ie);
      rd(`ACSC_OFS_RES_LO);
      check("result lo", rd_v, exp[7:0]);
      rd(`ACSC_OFS_RES_HI);
      check("result hi", rd_v, {6'h00, exp[9:8]});
      repeat ($urandom % 8) @(posedge clk_sys_in);
      rd(`ACSC_OFS_CTRL);
      check("done held", rd_v[5], 1'b1);
      wr(`ACSC_OFS_CTRL, {4'h0, ie, s});
      rd(`ACSC_OFS_CTRL);
      check("done cleared", rd_v, {4'h0, ie, s});
      check("irq cleared", irq, 1'b0);
   endtask

   initial begin
      seed_v = $urandom(32'hB7691F3F);
      repeat (4) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      rd(`ACSC_OFS_CHAN);
      check("chan reset", rd_v, 8'h00);
      rd(`ACSC_OFS_CTRL);
      check("ctrl reset", rd_v, 8'h00);
      rd(`ACSC_OFS_CFG);
      check("div reset", rd_v[7:3], `ACSC_RST_DIV);
      rd(8'h00);
      check("unmapped read", rd_v, 8'h00);
      v = 8'($urandom) | 8'hE0;
      wr(`ACSC_OFS_CHAN, v);
      rd(`ACSC_OFS_CHAN);
      check("chan rw", rd_v, {3'h0, v[4:0]});
      check("chan out", chan, v[4:0]);
      for (int rep = 0; rep < 2; rep++) begin
         for (int s = 0; s < 6; s++) begin
            div = (s == 0) ? ((rep == 0) ? 5'h00 : 5'h1F) : 5'($urandom);
            ie = 1'($urandom);
            u_acsc_far_model.set_modes(1'($urandom), 1'($urandom));
            wr(`ACSC_OFS_CFG, {div, 3'h0});
            wr(`ACSC_OFS_CTRL, {4'h0, ie, 3'(s)});
            s0 = start_cnt;
            if (s != 0) wr(`ACSC_OFS_CTRL, {4'h1, ie, 3'(s)});
            for (int k = 0; k < 7; k++) begin
               if (k != right_ev(3'(s), m2, m3)) u_acsc_far_model.fire(k);
            end
            repeat (3) @(posedge clk_sys_in);
            check("stray start", 16'(start_cnt - s0), 16'h0000);
            s0 = start_cnt;
            if (s == 0) wr(`ACSC_OFS_CTRL, {4'h1, ie, 3'h0});
            else u_acsc_far_model.fire(right_ev(3'(s), m2, m3));
            run_conv(3'(s));
         end
      end
      for (int s = 6; s < 8; s++) begin
         wr(`ACSC_OFS_CTRL, {4'h0, 1'b0, 3'(s)});
         s0 = start_cnt;
         wr(`ACSC_OFS_CTRL, {4'h1, 1'b0, 3'(s)});
         for (int k = 0; k < 7; k++) u_acsc_far_model.fire(k);
         repeat (3) @(posedge clk_sys_in);
         check("no source", 16'(start_cnt - s0), 16'h0000);
      end
      // reset in mid-conversion
      wr(`ACSC_OFS_CTRL, {4'h0, 1'b0, `ACSC_SRC_SW});
      wr(`ACSC_OFS_CTRL, {4'h1, 1'b0, `ACSC_SRC_SW});
      repeat (5) @(posedge clk_sys_in);
      nrst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      rd(`ACSC_OFS_CHAN);
      check("chan after reset", rd_v, 8'h00);
      check("chan out after reset", chan, 5'h00);
      check("busy after reset", busy, 1'b0);
      rd(`ACSC_OFS_CFG);
      check("div after reset", rd_v[7:3], `ACSC_RST_DIV);
      close_out();
   end
endmodule
